/* wdt_pkg.sv */
// Constants shared by the crystal watchdog and its unlock logic
package wdt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 27;

  // Register addresses
  localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] UNLOCK_ADDR = 8'hc7;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hd8;
  localparam logic [7:0] EXTENDED_IRQ_ENABLE_ADDR = 8'he8;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hf0;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hf1;

  // Unlock sequence
  localparam logic [7:0] UNLOCK_FIRST = 8'haa;
  localparam logic [7:0] UNLOCK_SECOND = 8'h55;
  localparam logic [1:0] WINDOW_CYCLES = 2'h3;

  // Field positions
  localparam int PERIOD_SELECT_HI_BIT = 7;
  localparam int PERIOD_SELECT_LO_BIT = 6;
  localparam int POR_FLAG_BIT = 6;
  localparam int EARLY_WARNING_FLAG_BIT = 3;
  localparam int TIMEOUT_RESET_FLAG_BIT = 2;
  localparam int TIMEOUT_RESET_ENABLE_BIT = 1;
  localparam int COUNTER_RESTART_BIT = 0;
  localparam int EARLY_WARNING_IRQ_ENABLE_BIT = 4;
  localparam int IRQ_EARLY_BIT = 0;
  localparam int IRQ_TIMEOUT_BIT = 1;

  // Reset values
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] EXTENDED_IRQ_ENABLE_RESET = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic POR_FLAG_RESET = 1'b1;

  // Interrupt count exponents and the gap to full expiry
  localparam int EXP_SEL0 = 17;
  localparam int EXP_SEL1 = 20;
  localparam int EXP_SEL2 = 23;
  localparam int EXP_SEL3 = 26;
  localparam logic [CNT_W-1:0] POST_COUNT = 27'h000_0200;
endpackage

/* timed_access_unlock.sv */
// Two-write unlock sequence that opens a short window for protected writes
`timescale 1ns/100ps
module timed_access_unlock
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
  output logic o_open
);
  import wdt_pkg::*;

  typedef enum logic [0:0] {IDLE, GOT_FIRST} unlock_state_t;

  unlock_state_t state;
  unlock_state_t next_state;
  logic [1:0] left;
  logic [1:0] next_left;

  wire logic hit_unlock = i_wr && (i_addr == UNLOCK_ADDR);
  wire logic first_seen = hit_unlock && (i_wdata == UNLOCK_FIRST);
  wire logic unlock = (state == GOT_FIRST) && hit_unlock && (i_wdata == UNLOCK_SECOND);

  // Any other write, except a repeat of the first value, breaks the sequence; reads do not
  always_comb
  begin
    next_state = state;
    case (state)
      IDLE:
        if (first_seen)
          next_state = GOT_FIRST;
      GOT_FIRST:
        if (i_wr)
          next_state = first_seen ? GOT_FIRST : IDLE;
      default:
        next_state = IDLE;
    endcase
  end

  assign next_left = unlock ? WINDOW_CYCLES : (left != 2'h0 ? left - 2'h1 : 2'h0);

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= IDLE;
      left <= 2'h0;
    end
    else
    begin
      state <= next_state;
      left <= next_left;
    end
  end

  assign o_open = (left != 2'h0);

  win_open_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) unlock |=> o_open [*3])
    else $error("window did not stay open three cycles");
  win_close_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) (left == 2'h1 && !unlock) |=> !o_open)
    else $error("window stayed open too long");
  win_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_open) |-> $past(unlock))
    else $error("window opened without unlock sequence");
  unlock_seen_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) unlock);
endmodule

/* crystal_watchdog_timer.sv */
// Crystal-clocked watchdog with early warning, expiry reset and register port
`timescale 1ns/100ps
module crystal_watchdog_timer
#(
  parameter int P_EXP_SEL0 = wdt_pkg::EXP_SEL0,
  parameter int P_EXP_SEL1 = wdt_pkg::EXP_SEL1,
  parameter int P_EXP_SEL2 = wdt_pkg::EXP_SEL2,
  parameter int P_EXP_SEL3 = wdt_pkg::EXP_SEL3
)
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [wdt_pkg::DATA_W-1:0] o_rdata,
  output logic o_cpu_reset,
  output logic o_early_warning_irq,
  output logic o_wake,
  output logic o_irq
);
  import wdt_pkg::*;

  logic rst_meta;
  logic rst_n;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [7:0] clock_control;
  logic [7:0] extended_irq_enable;
  logic por_flag;
  logic early_warning_flag;
  logic timeout_reset_flag;
  logic timeout_reset_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic cpu_reset;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic window_open;

  // Interrupt count minus one for a given exponent
  function automatic logic [CNT_W-1:0] int_point_of(input int exp_bits);
    logic [CNT_W:0] full;
    full = (CNT_W+1)'(1) << exp_bits;
    return CNT_W'(full - (CNT_W+1)'(1));
  endfunction

  // Release reset through two flops; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  timed_access_unlock unlock_inst
  (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_open(window_open)
  );

  // Address decode
  wire logic wr_clock_control = i_wr && (i_addr == CLOCK_CONTROL_ADDR);
  wire logic wr_watchdog_control = i_wr && (i_addr == WATCHDOG_CONTROL_ADDR);
  wire logic wr_extended_irq_enable = i_wr && (i_addr == EXTENDED_IRQ_ENABLE_ADDR);
  wire logic wr_irq_mask = i_wr && (i_addr == IRQ_MASK_ADDR);
  wire logic rd_irq_status = i_rd && (i_addr == IRQ_STATUS_ADDR);
  wire logic wr_protected = wr_watchdog_control && window_open;

  // Period select
  wire logic [1:0] period_select = {clock_control[PERIOD_SELECT_HI_BIT], clock_control[PERIOD_SELECT_LO_BIT]};
  wire logic [CNT_W-1:0] int_point =
    (period_select == 2'h0) ? int_point_of(P_EXP_SEL0) :
    (period_select == 2'h1) ? int_point_of(P_EXP_SEL1) :
    (period_select == 2'h2) ? int_point_of(P_EXP_SEL2) :
    int_point_of(P_EXP_SEL3);
  wire logic [CNT_W-1:0] reset_point = int_point + POST_COUNT;

  // Restart needs the unlock window; a locked write of 1 is dropped
  wire logic counter_restart = wr_protected && i_wdata[COUNTER_RESTART_BIT];
  wire logic early_event = (count == int_point) && !counter_restart;
  wire logic timeout_event = (count == reset_point) && !counter_restart;

  // Changing the period mid-count can leave the count past the new end;
  // it then wraps the full width first, which is why software restarts first.
  assign next_count = counter_restart ? '0 :
    (count == reset_point) ? '0 : count + CNT_W'(1);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else
      count <= next_count;
  end

  // Control registers
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_control <= CLOCK_CONTROL_RESET;
      extended_irq_enable <= EXTENDED_IRQ_ENABLE_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_clock_control)
        clock_control <= i_wdata;
      if (wr_extended_irq_enable)
        extended_irq_enable <= i_wdata;
      if (wr_irq_mask)
        irq_mask <= i_wdata[1:0];
    end
  end

  // Flags: a set in the same cycle as a clear wins
  wire logic next_early_warning_flag = early_event ||
    (wr_protected ? i_wdata[EARLY_WARNING_FLAG_BIT] : early_warning_flag);
  wire logic next_timeout_reset_flag = timeout_event ||
    (wr_watchdog_control ? i_wdata[TIMEOUT_RESET_FLAG_BIT] : timeout_reset_flag);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_flag <= POR_FLAG_RESET;
      early_warning_flag <= 1'b0;
      timeout_reset_flag <= 1'b0;
      timeout_reset_enable <= 1'b0;
    end
    else
    begin
      early_warning_flag <= next_early_warning_flag;
      timeout_reset_flag <= next_timeout_reset_flag;
      if (wr_protected)
      begin
        por_flag <= i_wdata[POR_FLAG_BIT];
        timeout_reset_enable <= i_wdata[TIMEOUT_RESET_ENABLE_BIT];
      end
    end
  end

  // Processor reset pulse on full expiry
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      cpu_reset <= 1'b0;
    else
      cpu_reset <= timeout_event && timeout_reset_enable;
  end

  // Sticky interrupt status, cleared by reading it; new events win
  wire logic [1:0] irq_events = {timeout_event, early_event};
  wire logic [1:0] next_irq_status = irq_events | (rd_irq_status ? 2'h0 : irq_status);

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= 2'h0;
    else
      irq_status <= next_irq_status;
  end

  // Read mux; restart always reads as zero, unmapped reads zero
  wire logic [7:0] watchdog_control_view = {1'b0, por_flag, 2'b00, early_warning_flag,
    timeout_reset_flag, timeout_reset_enable, 1'b0};
  wire logic [7:0] read_mux =
    (i_addr == CLOCK_CONTROL_ADDR) ? clock_control :
    (i_addr == WATCHDOG_CONTROL_ADDR) ? watchdog_control_view :
    (i_addr == EXTENDED_IRQ_ENABLE_ADDR) ? extended_irq_enable :
    (i_addr == IRQ_STATUS_ADDR) ? {6'b00_0000, irq_status} :
    (i_addr == IRQ_MASK_ADDR) ? {6'b00_0000, irq_mask} :
    8'h00;
  assign next_rdata = i_rd ? read_mux : 8'h00;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  assign o_rdata = rdata;
  assign o_cpu_reset = cpu_reset;
  assign o_early_warning_irq = early_warning_flag && extended_irq_enable[EARLY_WARNING_IRQ_ENABLE_BIT];
  // Wake needs no running CPU clock, only the enabled request
  assign o_wake = o_early_warning_irq;
  assign o_irq = |(irq_status & irq_mask);

  // Checks
  early_set_a: assert property (@(posedge i_mclk) disable iff (!rst_n) early_event |=> early_warning_flag)
    else $error("early warning flag not set at interrupt count");
  early_point_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    ($rose(early_warning_flag) && !$past(wr_protected)) |-> $past(count) == $past(int_point))
    else $error("early warning flag set at wrong count");
  gap_512_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    timeout_event |-> $past(early_event, 512))
    else $error("expiry not 512 clocks after early warning");
  expiry_flag_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    timeout_event |=> timeout_reset_flag && count == '0)
    else $error("timeout flag not set on expiry");
  reset_on_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (timeout_event && timeout_reset_enable) |=> o_cpu_reset)
    else $error("enabled expiry gave no processor reset");
  reset_off_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    o_cpu_reset |-> $past(timeout_reset_enable) && $past(timeout_event))
    else $error("processor reset without enabled expiry");
  restart_count_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    counter_restart |=> count == '0 ##1 (count == CNT_W'(1) || $past(counter_restart)))
    else $error("restart did not begin a new interval");
  locked_write_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (wr_watchdog_control && !window_open) |=> $stable(timeout_reset_enable) && $stable(por_flag))
    else $error("protected bit changed outside window");
  flag_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (early_warning_flag && !wr_protected) |=> early_warning_flag)
    else $error("early warning flag cleared itself");
  irq_gate_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
    o_early_warning_irq |-> early_warning_flag && extended_irq_enable[EARLY_WARNING_IRQ_ENABLE_BIT])
    else $error("early warning request without enable");

  early_c: cover property (@(posedge i_mclk) disable iff (!rst_n) early_event);
  expiry_c: cover property (@(posedge i_mclk) disable iff (!rst_n) timeout_event);
  cpu_reset_c: cover property (@(posedge i_mclk) disable iff (!rst_n) o_cpu_reset);
  restart_c: cover property (@(posedge i_mclk) disable iff (!rst_n) counter_restart);
endmodule

/* crystal_watchdog_timer_tb.sv */
// Self-checking testbench for the crystal watchdog
`timescale 1ns/100ps
module crystal_watchdog_timer_tb;
  import wdt_pkg::*;
  // Short exponents keep the run brief; they must stay consecutive for period()
  localparam int T_EXP0 = 4;
  localparam int LIMIT = 4000;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_cpu_reset;
  logic o_early_warning_irq;
  logic o_wake;
  logic o_irq;
  logic [31:0] seed = 32'ha0f1;
  logic [7:0] d;
  int k;
  int miscompares = 0;
  int n_tests = 0;

  always #20 i_mclk = ~i_mclk;

  crystal_watchdog_timer #(.P_EXP_SEL0(T_EXP0), .P_EXP_SEL1(T_EXP0 + 1), .P_EXP_SEL2(T_EXP0 + 2),
    .P_EXP_SEL3(T_EXP0 + 3)) u_crystal_watchdog_timer (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cpu_reset(o_cpu_reset), .o_early_warning_irq(o_early_warning_irq), .o_wake(o_wake), .o_irq(o_irq));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Clocks from restart to the early warning flag
  function automatic int period(input logic [1:0] s);
    return 1 << (T_EXP0 + int'(s));
  endfunction

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic unlock;
    wr(UNLOCK_ADDR, UNLOCK_FIRST);
    wr(UNLOCK_ADDR, UNLOCK_SECOND);
  endtask

  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h40);
    rd(CLOCK_CONTROL_ADDR, d);
    check_val(d, CLOCK_CONTROL_RESET);
    rd(EXTENDED_IRQ_ENABLE_ADDR, d);
    check_val(d, EXTENDED_IRQ_ENABLE_RESET);
    rd(IRQ_STATUS_ADDR, d);
    check_val(d, 8'h00);
    rd(UNLOCK_ADDR, d);
    check_val(d, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      seed = xorshift(seed);
      wr(CLOCK_CONTROL_ADDR, seed[7:0]);
      wr({4'h1, seed[11:8]}, seed[19:12]);
      rd(CLOCK_CONTROL_ADDR, d);
      check_val(d, seed[7:0]);
      rd({4'h2, seed[15:12]}, d);
      check_val(d, 8'h00);
    end
    $display("test random register access done");
    wr(EXTENDED_IRQ_ENABLE_ADDR, 8'h10);
    for (int s = 0; s < 4; s++)
    begin
      unlock();
      wr(WATCHDOG_CONTROL_ADDR, 8'h01);
      wr(CLOCK_CONTROL_ADDR, {s[1:0], 6'h00});
      unlock();
      wr(WATCHDOG_CONTROL_ADDR, 8'h03);
      k = 0;
      do
      begin
        @(posedge i_mclk);
        #1;
        k++;
      end
      while (o_early_warning_irq !== 1'b1 && k < LIMIT);
      check_cnt(k, period(s[1:0]));
      check_val({7'h00, o_wake}, 8'h01);
      do
      begin
        @(posedge i_mclk);
        #1;
        k++;
      end
      while (o_cpu_reset !== 1'b1 && k < LIMIT);
      check_cnt(k, period(s[1:0]) + 512);
      if (k >= LIMIT)
      begin
        stop_test();
      end
      @(posedge i_mclk);
      #1;
      check_val({7'h00, o_cpu_reset}, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, d);
      check_val(d, 8'h0e);
    end
    $display("test time-out lengths done");
    // Outside any window only the expiry flag may change
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h0a);
    unlock();
    repeat (3) @(posedge i_mclk);
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h0a);
    unlock();
    wr(WATCHDOG_CONTROL_ADDR, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h00);
    wr(UNLOCK_ADDR, UNLOCK_FIRST);
    wr(CLOCK_CONTROL_ADDR, 8'hc0);
    wr(UNLOCK_ADDR, UNLOCK_SECOND);
    wr(WATCHDOG_CONTROL_ADDR, 8'h08);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h00);
    $display("test protected writes done");
    unlock();
    wr(WATCHDOG_CONTROL_ADDR, 8'h01);
    wr(CLOCK_CONTROL_ADDR, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h02);
    unlock();
    wr(WATCHDOG_CONTROL_ADDR, 8'h01);
    rd(IRQ_STATUS_ADDR, d);
    repeat (20) @(posedge i_mclk);
    #1;
    check_val({7'h00, o_irq}, 8'h00);
    check_val({7'h00, o_early_warning_irq}, 8'h01);
    wr(IRQ_MASK_ADDR, 8'h03);
    #1;
    check_val({7'h00, o_irq}, 8'h01);
    rd(IRQ_STATUS_ADDR, d);
    check_val(d, 8'h01);
    check_val({7'h00, o_irq}, 8'h00);
    wr(EXTENDED_IRQ_ENABLE_ADDR, 8'h00);
    #1;
    check_val({6'h00, o_early_warning_irq, o_wake}, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h08);
    $display("test interrupt masking done");
    // Reset enable is clear: expiry gives flags and status but no processor reset
    k = 0;
    do
    begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    while (o_irq !== 1'b1 && k < LIMIT);
    check_val({6'h00, o_irq, o_cpu_reset}, 8'h02);
    rd(WATCHDOG_CONTROL_ADDR, d);
    check_val(d, 8'h0c);
    $display("test disabled reset done");
    stop_test();
  end
endmodule
